// ### src/oag_core.sv
// Operand address generator with register file and status word
`timescale 1ns/1ps
`default_nettype none
module oag_core
  #(parameter int NUM_IRQ = 8)
  (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Decoded instruction
  input wire logic start_i,
  input wire logic [2:0] mode_i,
  input wire logic [1:0] width_i,
  input wire logic [7:0] reg_sel_i,
  input wire logic [15:0] disp_i,
  input wire logic [7:0] dir_a_i,
  input wire logic [7:0] dir_b_i,
  input wire logic [1:0] dir_cnt_i,
  // Register file write port from execution
  input wire logic rf_we_i,
  input wire logic [7:0] rf_waddr_i,
  input wire logic [15:0] rf_wdata_i,
  input wire logic rf_wword_i,
  // Status word control
  input wire logic push_status_word_i,
  input wire logic pop_status_word_i,
  input wire logic [15:0] pop_data_i,
  input wire logic flags_we_i,
  input wire logic [7:0] flags_i,
  // Interrupt requests
  input wire logic [NUM_IRQ-1:0] irq_i,
  input wire logic irq_ack_i,
  input wire logic [NUM_IRQ-1:0] irq_ack_vec_i,
  // Results
  output logic valid_o,
  output logic [15:0] addr_o,
  output logic is_mem_o,
  output logic [15:0] imm_o,
  output logic misaligned_o,
  output logic [15:0] stack_pointer_o,
  output logic [15:0] program_status_word_o,
  output logic [15:0] push_data_o,
  output logic [NUM_IRQ-1:0] pending_o,
  output logic [NUM_IRQ-1:0] irq_grant_o
  );

  // Register file storage
  logic [7:0] rf [0:255];
  // Status word and stack pointer
  logic [15:0] status_word;
  logic [15:0] stack_ptr;
  // Latched pending interrupts
  logic [NUM_IRQ-1:0] pend;

  // Word read with the zero register and mapped registers
  function automatic logic [15:0] rd_word(input logic [7:0] a);
    logic [7:0] ae;
    ae = {a[7:1], 1'b0};
    if (ae == oag_pkg::ZERO_ADDR)
      rd_word = 16'h0000;
    else if (ae == oag_pkg::STACK_PTR_ADDR)
      rd_word = stack_ptr;
    else if (ae == oag_pkg::MASK_ADDR)
      rd_word = {rf[ae + 8'h01], status_word[7:0]};
    else
      rd_word = {rf[ae + 8'h01], rf[ae]};
  endfunction

  // Alignment check by operand width
  function automatic logic bad_align(input logic [15:0] a,
                                     input logic [1:0] w);
    if (w == 2'(oag_pkg::OAG_WORD))
      bad_align = a[0];
    else if (w == 2'(oag_pkg::OAG_DWORD))
      bad_align = |a[1:0];
    else
      bad_align = 1'b0;
  endfunction

  // Pointer and effective address computation
  logic [15:0] ptr;
  logic [15:0] step;
  logic [15:0] next_addr;
  logic next_mem;
  logic next_bad;
  always_comb
  begin
    ptr = rd_word(reg_sel_i);
    step = (width_i == 2'(oag_pkg::OAG_BYTE)) ?
      oag_pkg::STEP_BYTE : oag_pkg::STEP_WORD;
    next_mem = 1'b1;
    case (oag_pkg::oag_mode_t'(mode_i))
      oag_pkg::OAG_DIRECT:
      begin
        next_addr = {8'h00, reg_sel_i};
        next_mem = 1'b0;
      end
      oag_pkg::OAG_INDIRECT, oag_pkg::OAG_INDIRECT_INC:
        next_addr = ptr;
      oag_pkg::OAG_IMMEDIATE:
      begin
        next_addr = 16'h0000;
        next_mem = 1'b0;
      end
      oag_pkg::OAG_SHORT_IDX:
        next_addr = ptr + {{8{disp_i[7]}}, disp_i[7:0]};
      oag_pkg::OAG_LONG_IDX:
        next_addr = ptr + disp_i;
      default:
      begin
        next_addr = 16'h0000;
        next_mem = 1'b0;
      end
    endcase
    // Mode operand must be aligned, as must each direct operand
    next_bad = bad_align(next_addr, width_i)
      | ((dir_cnt_i != 2'd0) && bad_align({8'h00, dir_a_i}, width_i))
      | ((dir_cnt_i == 2'd2) && bad_align({8'h00, dir_b_i}, width_i))
      | (dir_cnt_i == 2'd3);
  end

  // Result outputs
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      valid_o <= 1'b0;
      addr_o <= 16'h0000;
      is_mem_o <= 1'b0;
      imm_o <= 16'h0000;
      misaligned_o <= 1'b0;
    end
    else
    begin
      valid_o <= start_i;
      if (start_i)
      begin
        addr_o <= next_addr;
        is_mem_o <= next_mem;
        // Byte immediate uses low eight bits only
        imm_o <= (width_i == 2'(oag_pkg::OAG_BYTE)) ?
          {8'h00, disp_i[7:0]} : disp_i;
        misaligned_o <= next_bad;
      end
    end
  end

  // Register file writes, including pointer write-back
  always_ff @(posedge clk_i)
  begin
    if (start_i && mode_i == 3'(oag_pkg::OAG_INDIRECT_INC)
        && reg_sel_i[7:1] != 7'h00
        && {reg_sel_i[7:1], 1'b0} != oag_pkg::STACK_PTR_ADDR
        && {reg_sel_i[7:1], 1'b0} != oag_pkg::MASK_ADDR)
    begin
      rf[{reg_sel_i[7:1], 1'b0}] <= 8'(ptr + step);
      rf[{reg_sel_i[7:1], 1'b1}] <= 8'((ptr + step) >> 8);
    end
    else if (rf_we_i && rf_waddr_i[7:1] != 7'h00)
    begin
      rf[rf_waddr_i] <= rf_wdata_i[7:0];
      if (rf_wword_i)
        rf[rf_waddr_i + 8'h01] <= rf_wdata_i[15:8];
    end
  end

  // Stack pointer: register write or post-increment write-back
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      stack_ptr <= oag_pkg::STACK_PTR_RST;
    else if (start_i && mode_i == 3'(oag_pkg::OAG_INDIRECT_INC)
             && {reg_sel_i[7:1], 1'b0} == oag_pkg::STACK_PTR_ADDR)
      stack_ptr <= ptr + step;
    else if (rf_we_i && rf_wword_i && rf_waddr_i == oag_pkg::STACK_PTR_ADDR)
      stack_ptr <= rf_wdata_i;
  end

  // Status word: pop, flag updates and mask byte writes
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      status_word <= oag_pkg::STAT_RST;
    else if (pop_status_word_i)
      status_word <= pop_data_i;
    else
    begin
      if (flags_we_i)
        status_word[15:8] <= flags_i;
      if (rf_we_i && rf_waddr_i == oag_pkg::MASK_ADDR)
        status_word[7:0] <= rf_wdata_i[7:0];
    end
  end

  // Pending latch: new request wins over acknowledge
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      pend <= '0;
    else
      pend <= (pend & ~(irq_ack_i ? irq_ack_vec_i : '0)) | irq_i;
  end

  // Grant the lowest numbered enabled pending source
  logic [NUM_IRQ-1:0] enabled;
  logic [NUM_IRQ-1:0] next_grant;
  always_comb
  begin
    enabled = pend & status_word[NUM_IRQ-1:0]
      & {NUM_IRQ{status_word[oag_pkg::STAT_GIE]}};
    next_grant = enabled & (~enabled + 1'b1);
  end

  // Status outputs
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      stack_pointer_o <= oag_pkg::STACK_PTR_RST;
      program_status_word_o <= oag_pkg::STAT_RST;
      push_data_o <= oag_pkg::STAT_RST;
      pending_o <= '0;
      irq_grant_o <= '0;
    end
    else
    begin
      stack_pointer_o <= stack_ptr;
      program_status_word_o <= status_word;
      if (push_status_word_i)
        push_data_o <= status_word;
      pending_o <= pend;
      irq_grant_o <= next_grant;
    end
  end

  // Assertions
  a_short_index: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    start_i && mode_i == 3'(oag_pkg::OAG_SHORT_IDX) |=> addr_o ==
    $past(ptr) + {{8{$past(disp_i[7])}}, $past(disp_i[7:0])})
    else $error("short index address wrong");
  a_long_index: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    start_i && mode_i == 3'(oag_pkg::OAG_LONG_IDX) && reg_sel_i == 8'h00
    |=> addr_o == $past(disp_i))
    else $error("zero based address wrong");
  a_direct_sel: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    start_i && mode_i == 3'(oag_pkg::OAG_DIRECT)
    |=> addr_o == {8'h00, $past(reg_sel_i)} && !is_mem_o)
    else $error("direct select wrong");
  // Pointer taken from the zero word must give address zero
  a_zero_base: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    start_i && mode_i == 3'(oag_pkg::OAG_INDIRECT)
    && reg_sel_i[7:1] == 7'h00 |=> addr_o == 16'h0000)
    else $error("zero word not zero");
  a_stack_incr: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    start_i && mode_i == 3'(oag_pkg::OAG_INDIRECT_INC)
    && reg_sel_i == oag_pkg::STACK_PTR_ADDR
    && width_i == 2'(oag_pkg::OAG_WORD) && !pop_status_word_i
    |=> stack_ptr == $past(stack_ptr) + 16'h0002)
    else $error("stack pointer increment wrong");
  a_gie_block: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    !status_word[oag_pkg::STAT_GIE] |=> irq_grant_o == '0)
    else $error("grant while disabled");
  a_pend_hold: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    irq_i[0] |=> pend[0])
    else $error("request lost");
  a_push_status: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    push_status_word_i |=> push_data_o == $past(status_word))
    else $error("pushed word wrong");
  a_word_align: assert property (
    @(posedge clk_i) disable iff (sys_rst_i)
    start_i && width_i == 2'(oag_pkg::OAG_WORD) && next_addr[0]
    |=> misaligned_o)
    else $error("odd word not flagged");
  c_indirect_inc: cover property (@(posedge clk_i)
    start_i && mode_i == 3'(oag_pkg::OAG_INDIRECT_INC));
  c_grant: cover property (@(posedge clk_i) irq_grant_o != '0);
  c_pop: cover property (@(posedge clk_i) pop_status_word_i);
endmodule // oag_core
`default_nettype wire

// ### src/oag_pkg.sv
// Package of constants for the operand address generation block
// Summary of operation
// - Register-direct selects register file byte by field
// - Up to two direct operands, aligned
// - Indirect reads pointer, addresses whole space
// - At most one indirect operand
// - Post-increment adds one or two
// - Immediate field byte or word wide
// - At most one immediate operand
// - Short index sign-extends eight-bit displacement
// - Long index adds sixteen-bit displacement
// - At most one indexed operand
// - Lowest register word always reads zero
// - Zero base gives absolute address
// - Stack pointer lives at register 18h
// - Status word flag layout in upper byte
// - Mask byte enables sources, at address 8
// - Bit 9 globally enables maskable interrupts
// - Requests stay pending while masked
// - Push and pop whole status word
// - Words even aligned, doubles divisible by four
package oag_pkg;
  // Register file locations
  localparam logic [7:0] ZERO_ADDR = 8'h00;
  localparam logic [7:0] MASK_ADDR = 8'h08;
  localparam logic [7:0] STACK_PTR_ADDR = 8'h18;
  // Status word bit positions
  localparam int STAT_Z = 15;
  localparam int STAT_N = 14;
  localparam int STAT_V = 13;
  localparam int STAT_OVF_TRAP = 12;
  localparam int STAT_C = 11;
  localparam int STAT_GIE = 9;
  localparam int STAT_STICKY = 8;
  // Reset values
  localparam logic [15:0] STAT_RST = 16'h0000;
  localparam logic [15:0] STACK_PTR_RST = 16'h0000;
  // Increment steps
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  // Addressing modes
  typedef enum logic [2:0] {
    OAG_DIRECT,
    OAG_INDIRECT,
    OAG_INDIRECT_INC,
    OAG_IMMEDIATE,
    OAG_SHORT_IDX,
    OAG_LONG_IDX
  } oag_mode_t;
  // Operand widths
  typedef enum logic [1:0] {
    OAG_BYTE,
    OAG_WORD,
    OAG_DWORD
  } oag_width_t;
endpackage

// ### test/oag_mem_model.sv
// Memory side model that counts operand accesses leaving the block
`timescale 1ns/1ps
`default_nettype none
module oag_mem_model
  (
  // Clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // Operand address from the block
  input wire logic valid_i,
  input wire logic [15:0] addr_i,
  input wire logic is_mem_i,
  // Number of memory accesses seen
  output logic [15:0] hits_o
  );
  // Any 16-bit address is accepted, register file included
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
      hits_o <= 16'h0000;
    else if (valid_i && is_mem_i && (addr_i !== 16'hxxxx))
      hits_o <= hits_o + 16'h0001;
  end
endmodule // oag_mem_model
`default_nettype wire

// ### test/tb_top.sv
// Self-checking bench for the operand address generator
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // Mode and width codes
  localparam logic [2:0] DI = oag_pkg::OAG_DIRECT;
  localparam logic [2:0] IN = oag_pkg::OAG_INDIRECT;
  localparam logic [2:0] IC = oag_pkg::OAG_INDIRECT_INC;
  localparam logic [2:0] IM = oag_pkg::OAG_IMMEDIATE;
  localparam logic [2:0] SI = oag_pkg::OAG_SHORT_IDX;
  localparam logic [2:0] LI = oag_pkg::OAG_LONG_IDX;
  localparam logic [1:0] B = oag_pkg::OAG_BYTE;
  localparam logic [1:0] W = oag_pkg::OAG_WORD;
  localparam logic [1:0] D = oag_pkg::OAG_DWORD;
  // Stimulus
  logic clk_i = 1'b0, sys_rst_i = 1'b1, start_i = 1'b0, rf_we_i = 1'b0;
  logic [2:0] mode_i = 3'h0;
  logic [1:0] width_i = 2'h0, dir_cnt_i = 2'h2;
  logic [7:0] reg_sel_i = 8'h00, dir_a_i = 8'h30, dir_b_i = 8'h34;
  logic [7:0] rf_waddr_i = 8'h00, flags_i = 8'h00, irq_i = 8'h00;
  logic [15:0] disp_i = 16'h0000, rf_wdata_i = 16'h0000;
  logic [15:0] pop_data_i = 16'h0000;
  logic rf_wword_i = 1'b0, push_i = 1'b0, pop_i = 1'b0, flags_we_i = 1'b0;
  logic irq_ack_i = 1'b0;
  logic [7:0] ack_vec = 8'h00;
  // Observed
  logic valid_o, is_mem_o, misaligned_o;
  logic [15:0] addr_o, imm_o, stack_o, status_o, push_data_o, hits;
  logic [7:0] pending_o, grant_o;
  int mismatches = 0;
  int n_compared = 0;
  // Core clock, 50 ns period
  always #25 clk_i = ~clk_i;
  oag_core oag_core_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .start_i(start_i), .mode_i(mode_i), .width_i(width_i),
    .reg_sel_i(reg_sel_i), .disp_i(disp_i), .dir_a_i(dir_a_i),
    .dir_b_i(dir_b_i), .dir_cnt_i(dir_cnt_i), .rf_we_i(rf_we_i),
    .rf_waddr_i(rf_waddr_i), .rf_wdata_i(rf_wdata_i),
    .rf_wword_i(rf_wword_i), .push_status_word_i(push_i),
    .pop_status_word_i(pop_i), .pop_data_i(pop_data_i),
    .flags_we_i(flags_we_i), .flags_i(flags_i), .irq_i(irq_i),
    .irq_ack_i(irq_ack_i), .irq_ack_vec_i(ack_vec), .valid_o(valid_o),
    .addr_o(addr_o), .is_mem_o(is_mem_o), .imm_o(imm_o),
    .misaligned_o(misaligned_o), .stack_pointer_o(stack_o),
    .program_status_word_o(status_o), .push_data_o(push_data_o),
    .pending_o(pending_o), .irq_grant_o(grant_o));
  oag_mem_model oag_mem_model_i (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
    .valid_i(valid_o), .addr_i(addr_o), .is_mem_i(is_mem_o),
    .hits_o(hits));
  // Step to just after the next rising edge
  task automatic nx;
    @(posedge clk_i);
    #5;
  endtask
  // Compare and count
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // One operand request; address checked for memory modes
  task automatic op(input logic [2:0] m, input logic [1:0] w,
    input logic [7:0] r, input logic [15:0] d, input logic [15:0] ea);
    {start_i, mode_i, width_i, reg_sel_i, disp_i} = {1'b1, m, w, r, d};
    nx;
    check({15'h0000, valid_o}, 16'h0001);
    if (m != DI && m != IM)
      check(addr_o, ea);
  endtask
  // Register file write from the execution side
  task automatic wr(input logic [7:0] a, input logic [15:0] d,
    input logic wd);
    start_i = 1'b0;
    {rf_we_i, rf_waddr_i, rf_wdata_i, rf_wword_i} = {1'b1, a, d, wd};
    nx;
    rf_we_i = 1'b0;
  endtask
  // Load the status word as if restored from the stack
  task automatic pop(input logic [15:0] d);
    {pop_i, pop_data_i} = {1'b1, d};
    nx;
    pop_i = 1'b0;
    repeat (2) nx;
  endtask
  task automatic t_index;
    wr(8'h00, 16'hffff, 1'b1);
    wr(8'h20, 16'h1000, 1'b1);
    op(LI, W, 8'h00, 16'h0040, 16'h0040);
    op(LI, W, 8'h00, 16'h1234, 16'h1234);
    op(IN, W, 8'h01, 16'h0000, 16'h0000);
    op(SI, W, 8'h20, 16'h0080, 16'h0f80);
    op(SI, B, 8'h20, 16'h007f, 16'h107f);
    op(LI, B, 8'h20, 16'hf123, 16'h0123);
  endtask
  task automatic t_indirect;
    wr(8'h22, 16'hfffe, 1'b1);
    op(IC, W, 8'h22, 16'h0000, 16'hfffe);
    op(IC, W, 8'h22, 16'h0000, 16'h0000);
    op(IC, B, 8'h22, 16'h0000, 16'h0002);
    op(IN, B, 8'h22, 16'h0000, 16'h0003);
    op(IN, B, 8'h22, 16'h0000, 16'h0003);
    wr(8'h18, 16'h4000, 1'b1);
    op(IN, W, 8'h18, 16'h0000, 16'h4000);
    op(IC, W, 8'h18, 16'h0000, 16'h4000);
    op(SI, W, 8'h18, 16'h0002, 16'h4004);
    check(stack_o, 16'h4002);
  endtask
  task automatic t_imm_align;
    op(IM, B, 8'h00, 16'h1234, 16'h0000);
    check(imm_o, 16'h0034);
    op(IM, W, 8'h00, 16'h1234, 16'h0000);
    check(imm_o, 16'h1234);
    op(DI, W, 8'h21, 16'h0000, 16'h0000);
    check({15'h0000, misaligned_o}, 16'h0001);
    op(DI, D, 8'h26, 16'h0000, 16'h0000);
    check({15'h0000, misaligned_o}, 16'h0001);
    op(DI, D, 8'h24, 16'h0000, 16'h0000);
    check({15'h0000, misaligned_o}, 16'h0000);
    dir_cnt_i = 2'h3;
    op(DI, W, 8'h24, 16'h0000, 16'h0000);
    check({15'h0000, misaligned_o}, 16'h0001);
    dir_cnt_i = 2'h2;
    start_i = 1'b0;
    nx;
    check(hits, 16'h000e);
  endtask
  task automatic t_status;
    {flags_we_i, flags_i} = {1'b1, 8'hb9};
    nx;
    flags_we_i = 1'b0;
    nx;
    check(status_o, 16'hb900);
    wr(8'h08, 16'h0003, 1'b0);
    nx;
    check(status_o, 16'hb903);
    push_i = 1'b1;
    nx;
    push_i = 1'b0;
    check(push_data_o, 16'hb903);
    pop(16'h0201);
    check(status_o, 16'h0201);
  endtask
  task automatic t_irq;
    pop(16'h0002);
    irq_i = 8'h03;
    repeat (3) nx;
    check({8'h00, pending_o}, 16'h0003);
    check({8'h00, grant_o}, 16'h0000);
    pop(16'h0202);
    check({8'h00, grant_o}, 16'h0002);
    {irq_i, irq_ack_i, ack_vec} = {8'h00, 1'b1, 8'h03};
    nx;
    irq_ack_i = 1'b0;
    nx;
    check({8'h00, pending_o}, 16'h0000);
  endtask
  // Verdict and end of run
  task automatic end_of_test;
    if (mismatches == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    #5;
    sys_rst_i = 1'b0;
    check(status_o, 16'h0000);
    t_index;
    t_indirect;
    t_imm_align;
    t_status;
    t_irq;
    end_of_test;
  end
endmodule // tb_top
`default_nettype wire
